// ===== logic/spi_master_slave_port.sv
// byte-serial port with master/slave role, apb registers
// assumes pins pass through pad logic outside; select for master is a gpio
// Notes on behaviour
// - byte transfers; master generates clock or slave follows external clock
// - full duplex on clock, mosi, miso and active-low select
// - control bit picks lsb-first or msb-first for both directions
// - master shifting starts only on a data register write
// - idle master write loads shifter and starts at once
// - master shifts exactly eight bits per transfer
// - each outgoing bit is replaced by an incoming bit
// - after last bit receive buffer loads (slave from shifter, master from rx_shift two clocks later), done flag raised
// - data register read returns receive buffer, not shifter
// - write while busy sets collision; transfer continues, value dropped
// - master drives data on mosi and clock on sck
// - master samples incoming data from miso
// - eight master clock rates
// - rate from two control bits and double-speed status bit
// - eight clock pulses per byte, then clock stops
// - phase and polarity bits; both ends must match
// - end-of-transmission flag raises interrupt request
// - port keeps running while processor idles
// - rate is fosc divided by 2 to 256, double speed picks faster
// - select low in master sets mode fault, clears master and the sck and mosi pin enables
// - slave select release mid-byte aborts without completion
// - collision clears on status read with flag then data access
//
// The implementer's own choices: the register addresses and register access over APB.
`timescale 1ns/1ns
module spi_master_slave_port
   import spi_port_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // serial pins
   input wire logic sck_in,
   output logic sck_out,
   output logic sck_oe,
   input wire logic mosi_in,
   output logic mosi_out,
   output logic mosi_oe,
   input wire logic miso_in,
   output logic miso_out,
   output logic miso_oe,
   input wire logic slave_select_n,
   // interrupt request to the core
   output logic transfer_irq
);
   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b00,
      ST_SHIFT = 2'b01,
      ST_WAIT_SEL = 2'b10
   } phase_t;

   typedef struct packed
   {
      phase_t phase;
      logic [7:0] port_control_reg;
      logic double_speed;
      logic transfer_done_flag;
      logic collision;
      logic mode_fault;
      logic [2:0] armed;
      logic [7:0] shifter;
      logic [7:0] rx_buffer;
      logic [7:0] tx_hold;
      logic tx_pending;
      logic [3:0] bit_count;
      logic edge_odd;
      logic sck_level;
      logic out_bit;
      logic sck_prev;
      logic [1:0] samp_dly;
      logic [7:0] rx_shift;
      logic [3:0] rx_count;
   } port_state_t;

   port_state_t state_reg;
   port_state_t state_next;

   logic [2:0] pins_sync;
   logic sck_s;
   logic mosi_s;
   logic miso_s;
   logic sel_n_s;
   logic tick;
   logic is_master;
   logic enabled;
   logic clock_phase_sel;
   logic clock_polarity_sel;
   logic lsb_first;
   logic bus_access;
   logic bus_write;
   logic bus_read;
   logic [7:0] wbyte;
   logic in_bit;
   logic slave_lead;
   logic slave_trail;
   logic sck_mode;
   logic [7:0] read_byte;

   function automatic logic pick_out(input logic [7:0] v, input logic lsb);
      pick_out = lsb ? v[0] : v[7];
   endfunction: pick_out

   function automatic logic [7:0] shift_in(input logic [7:0] v, input logic lsb,
                                           input logic b);
      shift_in = lsb ? {b, v[7:1]} : {v[6:0], b};
   endfunction: shift_in

   ////////////////////////////////////////////////////////////////////////////
   // pins and divider

   spi_pin_sync u_sync
   (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .pins_async({slave_select_n, mosi_in, sck_in}),
      .pins_sync(pins_sync)
   );
   // miso is sampled on the same synchronised timebase as the slave pins
   logic [1:0] miso_meta;
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
         miso_meta <= 2'h0;
      else
         miso_meta <= {miso_meta[0], miso_in};
   end
   assign miso_s = miso_meta[1];
   assign sck_s = pins_sync[0];
   assign mosi_s = pins_sync[1];
   assign sel_n_s = pins_sync[2];

   assign enabled = state_reg.port_control_reg[CTL_ENABLE];
   assign is_master = state_reg.port_control_reg[CTL_MASTER];
   assign clock_phase_sel = state_reg.port_control_reg[CTL_PHASE];
   assign clock_polarity_sel = state_reg.port_control_reg[CTL_POLARITY];
   assign lsb_first = state_reg.port_control_reg[CTL_LSB_FIRST];

   spi_clock_div u_div
   (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .run(state_reg.phase == ST_SHIFT && is_master),
      .reload(half_period(state_reg.port_control_reg[CTL_RATE_LO +: 2],
                          state_reg.double_speed)),
      .tick(tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // bus decode

   assign bus_access = psel && penable;
   assign bus_write = bus_access && pwrite;
   assign bus_read = bus_access && !pwrite;
   assign wbyte = pwdata[7:0];
   assign pready = 1'b1;
   assign pslverr = bus_access && paddr != OFS_CONTROL && paddr != OFS_STATUS
                    && paddr != OFS_DATA;
   // read data comes straight off the registers so it stands at the access edge
   assign prdata = {24'h000000, read_byte};

   // slave clock edges: leading edge leaves the idle level
   assign sck_mode = sck_s ^ clock_polarity_sel;
   assign slave_lead = !is_master && sck_mode && !(state_reg.sck_prev ^ clock_polarity_sel);
   assign slave_trail = !is_master && !sck_mode && (state_reg.sck_prev ^ clock_polarity_sel);
   assign in_bit = is_master ? miso_s : mosi_s;

   ////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb
   begin
      logic sample_now;
      logic change_now;
      logic finish;
      sample_now = 1'b0;
      change_now = 1'b0;
      finish = 1'b0;
      state_next = state_reg;
      state_next.sck_prev = sck_s;
      read_byte = DATA_RESET;

      // register reads; reads with flags set arm the clear sequence
      if (bus_read)
      begin
         unique case (paddr)
            OFS_CONTROL: read_byte = state_reg.port_control_reg;
            OFS_STATUS:
            begin
               read_byte[STS_DOUBLE] = state_reg.double_speed;
               read_byte[STS_MODE_FAULT] = state_reg.mode_fault;
               read_byte[STS_COLLISION] = state_reg.collision;
               read_byte[STS_DONE] = state_reg.transfer_done_flag;
               state_next.armed = {state_reg.mode_fault, state_reg.collision,
                                   state_reg.transfer_done_flag};
            end
            OFS_DATA: read_byte = state_reg.rx_buffer;
            default: read_byte = DATA_RESET;
         endcase
      end

      // data access finishes the clear for done and collision
      if (bus_access && paddr == OFS_DATA)
      begin
         if (state_reg.armed[0])
            state_next.transfer_done_flag = 1'b0;
         if (state_reg.armed[1])
            state_next.collision = 1'b0;
         state_next.armed[1:0] = 2'b00;
      end

      if (bus_write && paddr == OFS_CONTROL)
      begin
         state_next.port_control_reg = wbyte;
         if (state_reg.armed[2])
            state_next.mode_fault = 1'b0;
         state_next.armed[2] = 1'b0;
         if (!wbyte[CTL_ENABLE])
            state_next.phase = ST_IDLE;
      end
      if (bus_write && paddr == OFS_STATUS)
         state_next.double_speed = wbyte[STS_DOUBLE];

      // data write: load, hold for select, or collide
      if (bus_write && paddr == OFS_DATA && enabled)
      begin
         if (state_reg.phase == ST_SHIFT || state_reg.samp_dly != 2'b00)
            state_next.collision = 1'b1;
         else if (is_master || !sel_n_s)
         begin
            state_next.phase = ST_SHIFT;
            state_next.shifter = wbyte;
            state_next.bit_count = 4'h0;
            state_next.rx_count = 4'h0;
            state_next.edge_odd = 1'b0;
            state_next.sck_level = clock_polarity_sel;
            state_next.out_bit = pick_out(wbyte, lsb_first);
         end
         else
         begin
            state_next.phase = ST_WAIT_SEL;
            state_next.tx_hold = wbyte;
         end
         state_next.tx_pending = 1'b1;
      end

      // slave arms when select falls with a held byte
      if (state_reg.phase == ST_WAIT_SEL && !sel_n_s && !is_master)
      begin
         state_next.phase = ST_SHIFT;
         state_next.shifter = state_reg.tx_hold;
         state_next.bit_count = 4'h0;
         state_next.out_bit = pick_out(state_reg.tx_hold, lsb_first);
      end

      if (state_reg.phase == ST_SHIFT)
      begin
         if (is_master)
         begin
            // each tick toggles sck; 16 half periods give 8 pulses
            if (tick)
            begin
               state_next.edge_odd = !state_reg.edge_odd;
               state_next.sck_level = !state_reg.sck_level;
               sample_now = clock_phase_sel ? state_reg.edge_odd : !state_reg.edge_odd;
               change_now = !sample_now;
            end
         end
         else
         begin
            sample_now = clock_phase_sel ? slave_trail : slave_lead;
            change_now = clock_phase_sel ? slave_lead : slave_trail;
         end

         if (sample_now)
         begin
            state_next.shifter = shift_in(state_reg.shifter, lsb_first, in_bit);
            state_next.bit_count = state_reg.bit_count + 4'h1;
            finish = !is_master && state_reg.bit_count == BITS_PER_BYTE - 4'h1;
         end
         if (change_now)
            state_next.out_bit = pick_out(state_reg.shifter, lsb_first);

         if (finish)
         begin
            state_next.rx_buffer = shift_in(state_reg.shifter, lsb_first, in_bit);
            state_next.transfer_done_flag = 1'b1;
            state_next.tx_pending = 1'b0;
            state_next.phase = ST_IDLE;
         end
         // master ends on the sixteenth edge for either phase
         if (is_master && tick && state_reg.edge_odd
             && state_next.bit_count == BITS_PER_BYTE)
         begin
            state_next.phase = ST_IDLE;
            state_next.sck_level = clock_polarity_sel;
         end
      end

      // miso crosses two sync flops, so the master takes it two clocks late;
      // the bit still stands then, even at the fastest rate
      state_next.samp_dly = {state_reg.samp_dly[0], is_master && sample_now};
      if (is_master && state_reg.samp_dly[1])
      begin
         state_next.rx_shift = shift_in(state_reg.rx_shift, lsb_first, miso_s);
         state_next.rx_count = state_reg.rx_count + 4'h1;
         if (state_reg.rx_count == BITS_PER_BYTE - 4'h1)
         begin
            state_next.rx_buffer = shift_in(state_reg.rx_shift, lsb_first, miso_s);
            state_next.transfer_done_flag = 1'b1;
            state_next.tx_pending = 1'b0;
         end
      end

      // slave select released mid-byte: abort, no completion
      if (!is_master && sel_n_s && state_reg.phase == ST_SHIFT && !finish)
         state_next.phase = ST_IDLE;

      // select low while master: mode fault
      if (enabled && is_master && !sel_n_s)
      begin
         state_next.mode_fault = 1'b1;
         state_next.port_control_reg[CTL_MASTER] = 1'b0;
         state_next.transfer_done_flag = 1'b1;
         state_next.phase = ST_IDLE;
      end
      // new polarity applies at once, so idle level follows a control write
      if (state_next.phase == ST_IDLE)
         state_next.sck_level = state_next.port_control_reg[CTL_POLARITY];
   end

   // one register set; runs regardless of core idle state
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_reg <= '0;
         state_reg.phase <= ST_IDLE;
         state_reg.port_control_reg <= CONTROL_RESET;
         state_reg.sck_prev <= 1'b0;
      end
      else
         state_reg <= state_next;
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin drive; the select pin is never driven here

   assign sck_out = state_reg.sck_level;
   assign sck_oe = enabled && is_master;
   assign mosi_out = state_reg.out_bit;
   assign mosi_oe = enabled && is_master;
   assign miso_out = state_reg.out_bit;
   assign miso_oe = enabled && !is_master && !sel_n_s;
   assign transfer_irq = state_reg.transfer_done_flag
                         && state_reg.port_control_reg[CTL_IRQ_EN];

   ////////////////////////////////////////////////////////////////////////////
   // checks

   a_collision_sets: assert property (@(posedge clk_sys) disable iff (!reset_n)
      bus_write && paddr == OFS_DATA && enabled && state_reg.phase == ST_SHIFT
      |=> state_reg.collision && $stable(state_reg.tx_pending))
      else $error("write while busy did not flag collision");
   a_done_on_finish: assert property (@(posedge clk_sys) disable iff (!reset_n)
      $fell(state_reg.tx_pending) |-> state_reg.transfer_done_flag)
      else $error("completion without done flag");
   a_idle_clock: assert property (@(posedge clk_sys) disable iff (!reset_n)
      state_reg.phase == ST_IDLE |-> sck_out == clock_polarity_sel)
      else $error("serial clock not at idle level");
   a_master_start: assert property (@(posedge clk_sys) disable iff (!reset_n)
      is_master && sel_n_s && $past(state_reg.phase) == ST_IDLE && state_reg.phase == ST_SHIFT
      |-> $past(bus_write) && $past(paddr) == OFS_DATA)
      else $error("master shift began without data write");
   a_read_buffer: assert property (@(posedge clk_sys) disable iff (!reset_n)
      bus_read && paddr == OFS_DATA |-> prdata[7:0] == state_reg.rx_buffer)
      else $error("data read did not return receive buffer");
   a_mode_fault: assert property (@(posedge clk_sys) disable iff (!reset_n)
      enabled && is_master && !sel_n_s |=> state_reg.mode_fault && !is_master)
      else $error("mode fault not taken");
   a_slave_abort: assert property (@(posedge clk_sys) disable iff (!reset_n)
      !is_master && sel_n_s && state_reg.phase == ST_SHIFT && state_reg.bit_count < 4'h7
      |=> state_reg.phase == ST_IDLE)
      else $error("slave did not abort on select release");
   a_count_bound: assert property (@(posedge clk_sys) disable iff (!reset_n)
      state_reg.bit_count <= BITS_PER_BYTE)
      else $error("bit count past eight");
endmodule: spi_master_slave_port

// ===== logic/spi_port_pkg.sv
// constants for the byte-serial port: apb offsets, field positions, divider table
// assumes a 32-bit apb slave with byte addresses
package spi_port_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_CONTROL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_DATA = 8'h08;
   // control field positions
   localparam int CTL_RATE_LO = 0;
   localparam int CTL_PHASE = 2;
   localparam int CTL_POLARITY = 3;
   localparam int CTL_MASTER = 4;
   localparam int CTL_LSB_FIRST = 5;
   localparam int CTL_ENABLE = 6;
   localparam int CTL_IRQ_EN = 7;
   // status field positions
   localparam int STS_DOUBLE = 0;
   localparam int STS_MODE_FAULT = 4;
   localparam int STS_COLLISION = 6;
   localparam int STS_DONE = 7;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [7:0] DATA_RESET = 8'h00;

   // divider reload, one less than the half period in sys clocks, for a ratio index 0..7 (fosc/2 .. fosc/256)
   function automatic logic [7:0] half_period(input logic [1:0] rate, input logic dbl);
      logic [2:0] idx;
      idx = {rate, ~dbl};
      half_period = 8'(8'h01 << idx) - 8'h01;
   endfunction: half_period
endpackage: spi_port_pkg

// ===== logic/spi_clock_div.sv
// half-period tick generator for the master serial clock
// assumes a single sys clock domain
`timescale 1ns/1ns
module spi_clock_div
   import spi_port_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // control
   input wire logic run,
   input wire logic [7:0] reload,
   // tick out
   output logic tick
);
   typedef struct packed
   {
      logic [7:0] count;
   } div_state_t;
   div_state_t state_reg;
   div_state_t state_next;

   always_comb
   begin
      state_next = state_reg;
      if (!run || state_reg.count == 8'h00)
      begin
         state_next.count = reload;
      end
      else
      begin
         state_next.count = state_reg.count - 8'h01;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
         state_reg <= '{count: 8'h00};
      else
         state_reg <= state_next;
   end

   assign tick = run && state_reg.count == 8'h00;
endmodule: spi_clock_div

// ===== logic/spi_pin_sync.sv
// two-flop synchroniser for the serial pins
// assumes asynchronous pin inputs
`timescale 1ns/1ns
module spi_pin_sync
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // pins
   input wire logic [2:0] pins_async,
   output logic [2:0] pins_sync
);
   typedef struct packed
   {
      logic [2:0] first;
      logic [2:0] second;
   } sync_state_t;
   sync_state_t state_reg;
   sync_state_t state_next;

   always_comb
   begin
      state_next.first = pins_async;
      state_next.second = state_reg.first;
   end

   // select line rests high so it resets high
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
         state_reg <= '{first: 3'h4, second: 3'h4};
      else
         state_reg <= state_next;
   end

   assign pins_sync = state_reg.second;
endmodule: spi_pin_sync

// ===== sim/spi_slave_model.sv
// far-side slave device for the byte-serial port
// assumes the bench drives its select and mode settings
`timescale 1ns/1ns
module spi_slave_model
(
   // link
   input wire logic sck,
   input wire logic mosi,
   input wire logic sel_n,
   output logic miso,
   // setup
   input wire logic clock_polarity_sel,
   input wire logic clock_phase_sel,
   input wire logic lsb_first,
   input wire logic [7:0] tx_byte,
   output logic [7:0] rx_byte
);
   int ocnt = 0;
   int icnt = 0;
   logic bitv = 1'b0;
   initial rx_byte = 8'h00;

   // released line shows the inverse so a stale value cannot pass
   assign miso = sel_n ? ~bitv : bitv;

   function automatic int pos(input int k);
      pos = lsb_first ? k : 7 - k;
   endfunction: pos

   task automatic put_bit();
      if (ocnt < 8)
      begin
         bitv = tx_byte[pos(ocnt)];
         ocnt++;
      end
   endtask: put_bit

   //////////////////////////////
   always @(negedge sel_n)
   begin
      ocnt = 0;
      icnt = 0;
      if (!clock_phase_sel)
         put_bit();
   end

   // sample on leading edge for phase 0, trailing for phase 1
   always @(sck)
   begin
      if (!sel_n)
      begin
         if ((sck != clock_polarity_sel) ^ clock_phase_sel)
         begin
            if (icnt < 8)
               rx_byte[pos(icnt)] = mosi;
            icnt++;
         end
         else
            put_bit();
      end
   end
endmodule: spi_slave_model

// ===== sim/spi_master_slave_port_tb_top.sv
// bench for the byte-serial port in master role with a slave model
// assumes package, design and slave model are compiled first
`timescale 1ns/1ns
module spi_master_slave_port_tb_top
   import spi_port_pkg::*;
   ;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, rd_err;
   logic sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, s_miso, transfer_irq;
   logic slave_select_n = 1'b1;
   logic dev_sel_n = 1'b1;
   logic m_pol = 1'b0;
   logic m_pha = 1'b0;
   logic m_lsb = 1'b0;
   logic [7:0] s_tx = 8'h00;
   logic [7:0] s_rx;
   logic sck_prev = 1'b0;
   int toggles = 0;
   int gap_cnt = 0;
   int gap_seen = 0;
   int cycles = 0;
   int miscompares = 0;
   int tests_run = 0;

   always #2 clk_sys = ~clk_sys;

   spi_master_slave_port i_spi_master_slave_port (
      .clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .sck_in(sck_out), .sck_out(sck_out),
      .sck_oe(sck_oe), .mosi_in(mosi_out), .mosi_out(mosi_out), .mosi_oe(mosi_oe),
      .miso_in(miso_oe ? miso_out : s_miso), .miso_out(miso_out), .miso_oe(miso_oe),
      .slave_select_n(slave_select_n), .transfer_irq(transfer_irq));

   spi_slave_model i_spi_slave_model (
      .sck(sck_out), .mosi(mosi_out), .sel_n(dev_sel_n), .miso(s_miso), .clock_polarity_sel(m_pol),
      .clock_phase_sel(m_pha), .lsb_first(m_lsb), .tx_byte(s_tx), .rx_byte(s_rx));

   //////////////////////////////
   // clock edge monitor and hang limit
   always @(posedge clk_sys)
   begin
      cycles <= cycles + 1;
      sck_prev <= sck_out;
      gap_cnt <= (sck_out !== sck_prev) ? 1 : gap_cnt + 1;
      if (sck_out !== sck_prev)
      begin
         toggles <= toggles + 1;
         gap_seen <= gap_cnt;
      end
      if (cycles == 60000)
      begin
         miscompares++;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      $display("compared %0d, mismatched %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask: report_and_stop

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask: check

   // read data and error are taken at the edge that samples pready high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d = 32'h0);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1)
         @(posedge clk_sys);
      rd = prdata;
      rd_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask: apb

   //////////////////////////////
   task automatic xfer(input logic [7:0] ctl, input logic dbl, input logic [7:0] tx,
                       input logic [7:0] stx, input logic coll);
      int base;
      int hp;
      int n;
      hp = 1 << {ctl[1:0], ~dbl};
      m_pha = ctl[CTL_PHASE];
      m_pol = ctl[CTL_POLARITY];
      m_lsb = ctl[CTL_LSB_FIRST];
      s_tx = stx;
      apb(1'b1, OFS_CONTROL, {24'h0, ctl});
      apb(1'b1, OFS_STATUS, {31'h0, dbl});
      dev_sel_n <= 1'b0;
      repeat (4) @(posedge clk_sys);
      base = toggles;
      repeat (8) @(posedge clk_sys);
      check("no start", toggles - base, 32'h0);
      apb(1'b1, OFS_DATA, {24'h0, tx});
      if (coll)
         apb(1'b1, OFS_DATA, {24'h0, ~tx});
      n = 0;
      while (transfer_irq !== 1'b1 && n < 5000)
      begin
         @(posedge clk_sys);
         n++;
      end
      check("irq raised", transfer_irq, 1'b1);
      repeat (2 * hp + 4) @(posedge clk_sys);
      check("pulses", toggles - base, 32'h10);
      check("half period", gap_seen, hp);
      check("sck idle", sck_out, m_pol);
      check("slave rx", s_rx, tx);
      dev_sel_n <= 1'b1;
      apb(1'b0, OFS_STATUS);
      check("done", rd[STS_DONE], 1'b1);
      check("collision", rd[STS_COLLISION], coll);
      apb(1'b0, OFS_DATA);
      check("rx byte", rd, {24'h0, stx});
      check("irq clear", transfer_irq, 1'b0);
      apb(1'b0, OFS_STATUS);
      check("cleared", {rd[STS_DONE], rd[STS_COLLISION]}, 2'h0);
   endtask: xfer

   task automatic t_reset();
      apb(1'b0, OFS_CONTROL);
      check("control", rd, {24'h0, CONTROL_RESET});
      apb(1'b0, OFS_STATUS);
      check("status", rd, {24'h0, STATUS_RESET});
      apb(1'b0, OFS_DATA);
      check("data", rd, {24'h0, DATA_RESET});
      check("irq", transfer_irq, 1'b0);
      check("sck oe", sck_oe, 1'b0);
      apb(1'b1, 8'h0C, 32'hFF);
      check("unmapped", rd_err, 1'b1);
      $display("test reset done");
   endtask: t_reset

   // every rate setting, and every phase, polarity and order once
   task automatic t_modes();
      logic [2:0] i;
      for (int k = 0; k < 8; k++)
      begin
         i = 3'(k);
         xfer({2'h3, i[2], 1'b1, i[1], i[0], i[2:1]}, i[0], 8'hC1 ^ (8'h13 * i),
              8'h5E ^ (8'h29 * i), 1'b0);
      end
      $display("test modes done");
   endtask: t_modes

   task automatic t_collision();
      xfer(8'hD1, 1'b0, 8'h96, 8'h3A, 1'b1);
      $display("test collision done");
   endtask: t_collision

   task automatic t_fault();
      apb(1'b1, OFS_CONTROL, 32'hD0);
      slave_select_n <= 1'b0;
      repeat (6) @(posedge clk_sys);
      slave_select_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
      check("fault irq", transfer_irq, 1'b1);
      check("fault oe", {sck_oe, mosi_oe}, 2'h0);
      apb(1'b0, OFS_STATUS);
      check("fault flags", {rd[STS_DONE], rd[STS_MODE_FAULT]}, 2'h3);
      apb(1'b0, OFS_CONTROL);
      check("master off", rd[CTL_MASTER], 1'b0);
      apb(1'b1, OFS_CONTROL, 32'hD0);
      apb(1'b0, OFS_DATA);
      apb(1'b0, OFS_STATUS);
      check("fault clear", {rd[STS_DONE], rd[STS_MODE_FAULT]}, 2'h0);
      $display("test fault done");
   endtask: t_fault

   //////////////////////////////
   initial
   begin
      repeat (5) @(posedge clk_sys);
      reset_n <= 1'b1;
      @(posedge clk_sys);
      t_reset();
      t_modes();
      t_collision();
      t_fault();
      report_and_stop();
   end
endmodule: spi_master_slave_port_tb_top
